// file: src/xbc_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the bus control block
// Assumes: Included by its bare name
// Notes: Definitions only
`ifndef XBC_MAP_SVH
`define XBC_MAP_SVH

// ==========================================================================
// Register byte offsets
`define XBC_OFF_CTRL 8'h00
`define XBC_OFF_CONFIG 8'h04
`define XBC_OFF_ADDR 8'h08
`define XBC_OFF_LATCH 8'h0c
`define XBC_OFF_CMD 8'h10
`define XBC_OFF_STATUS 8'h14
`define XBC_OFF_RDATA 8'h18

// ==========================================================================
// Control register fields
`define XBC_CTRL_DIS_BIT 7
`define XBC_CTRL_WAIT_LSB 4
`define XBC_CTRL_WM_LSB 0
`define XBC_CTRL_RESET 8'h00
`define XBC_CTRL_MASK 8'hb3
`define XBC_CONFIG_RESET 1'b1

// ==========================================================================
// Timing
`define XBC_CLK_NS 25
`define XBC_TCY_NS 100
`define XBC_CLKS_PER_TCY (`XBC_TCY_NS / `XBC_CLK_NS)
`define XBC_FIFO_DEPTH 8

`endif

// file: src/xbc_pkg.sv
// Purpose: Types shared by the bus control block
// Assumes: Nothing
// Notes: Constants live in xbc_map.svh
package xbc_pkg;

    typedef struct packed {
        logic bus_disable_bit;
        logic [1:0] wait_field;
        logic [1:0] write_mode_field;
    } xbc_ctrl_type;

    typedef struct packed {
        logic is_write;
        logic [15:0] addr;
        logic [15:0] data;
    } xbc_cmd_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_DATA = 2'b10
    } xbc_state_type;

endpackage : xbc_pkg

// file: src/xbc_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: Output is the head entry, no extra latency
`timescale 1ns/10ps
`default_nettype none
module xbc_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 8
) (
    input wire logic clock, // Core clock
    input wire logic srst, // Synchronous reset
    input wire logic [WIDTH-1:0] in_data, // Entry to push
    input wire logic in_valid, // Push request
    output logic in_ready, // Room available
    output logic [WIDTH-1:0] out_data, // Head entry
    output logic out_valid, // Head present
    input wire logic out_ready // Pop request
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
    logic [AW:0] count_reg, count_next;
    logic push, pop;

    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem_reg[rptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wptr_next = push ? wptr_reg + 1'b1 : wptr_reg;
        rptr_next = pop ? rptr_reg + 1'b1 : rptr_reg;
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            count_reg <= '0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            count_reg <= count_next;
        end
        if (push) begin
            mem_reg[wptr_reg] <= in_data;
        end
    end
endmodule : xbc_fifo
`default_nettype wire

// file: src/xbc_top.sv
// Purpose: External memory bus control with Avalon-MM register access
// Assumes: Pins synchronous to clock; one instruction cycle is several core clocks
// Notes: Table reads/writes are queued as commands and run one at a time on the pins
`timescale 1ns/10ps
`default_nettype none
`include "xbc_map.svh"

// Summary of operation
// - In internal-only program memory mode the control register is disabled, writes ignored.
// - Bus-disable clear: interface owns pins permanently outside internal-only mode, ports and alternates blocked.
// - Bus-disable set: pins are ports, bus takes them only during accesses.
// - After reset bus-disable reads zero, so the bus owns the pins unless internal-only program memory mode is selected.
// - Wait field adds instruction cycles: 11 none, 10 one, 01 two, 00 three.
// - 16-bit write modes: 1x word plus high strobe; 01/00 byte duplicated.
// - In 8-bit width the write-mode field has no effect.
// - Variant without external bus: control register unimplemented, reads zero.
// - Each address/data pin drives its bit as digital output during address phases and write data phases.
// - During read cycles each address/data pin takes in its data bit.
// - While the bus owns a pin, the bus sets its direction, not the direction bit.
module xbc_top #(
    parameter bit HAS_EXT_BUS = 1'b1,
    parameter logic [7:0] CLKS_PER_TCY = 8'(`XBC_CLKS_PER_TCY),
    parameter int FIFO_DEPTH = `XBC_FIFO_DEPTH
) (
    input wire logic clock, // Core clock, 40 MHz
    input wire logic srst, // Synchronous reset, active high
    input wire logic [7:0] avs_address, // Avalon byte address
    input wire logic avs_read, // Avalon read
    input wire logic avs_write, // Avalon write
    input wire logic [31:0] avs_writedata, // Avalon write data
    input wire logic [3:0] avs_byteenable, // Avalon byte enables
    output logic [31:0] avs_readdata, // Avalon read data
    output logic avs_waitrequest, // Avalon wait request
    input wire logic internal_only_mode, // Program memory mode without external memory
    input wire logic [15:0] port_out, // Port latch values
    input wire logic [15:0] pin_direction_bit, // Port direction, 1 = input
    input wire logic [15:0] ad_in, // Pin levels
    output logic [15:0] ad_out, // Pin output values
    output logic [15:0] ad_oe, // Pin output enables
    output logic ale, // Address latch enable
    output logic oe_n, // Read strobe, active low
    output logic write_strobe_high_n, // High byte write strobe, active low
    output logic write_strobe_low_n, // Low byte write strobe, active low
    output logic ub_n, // Upper byte select, active low
    output logic lb_n, // Lower byte select, active low
    output logic bus_owns_pins // Pins given to the bus
);
    // ======================================================================
    // Register bus
    xbc_pkg::xbc_ctrl_type ctrl_reg, ctrl_next;
    logic width16_reg, width16_next;
    logic [15:0] addr_reg, addr_next, table_latch_reg, table_latch_next;
    logic [15:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next, wait_reg, wait_next;
    logic [31:0] readdata_next;
    logic ctrl_visible, wr_fire, rd_fire, push_cmd;
    logic fifo_in_ready, fifo_out_valid, fifo_pop;
    xbc_pkg::xbc_cmd_type fifo_in, fifo_out;

    function automatic logic [7:0] ctrl_word(input xbc_pkg::xbc_ctrl_type c);
        logic [7:0] w;
        w = 8'h00;
        w[`XBC_CTRL_DIS_BIT] = c.bus_disable_bit;
        w[`XBC_CTRL_WAIT_LSB +: 2] = c.wait_field;
        w[`XBC_CTRL_WM_LSB +: 2] = c.write_mode_field;
        return w;
    endfunction : ctrl_word

    assign ctrl_visible = HAS_EXT_BUS && !internal_only_mode;
    assign wr_fire = avs_write && !wait_reg;
    assign rd_fire = avs_read && !wait_reg;
    assign push_cmd = wr_fire && (avs_address == `XBC_OFF_CMD) && avs_byteenable[0];
    assign fifo_in = '{is_write: avs_writedata[0], addr: addr_reg, data: table_latch_reg};

    // Bus engine signals used by the register side
    xbc_pkg::xbc_state_type state_reg, state_next;
    xbc_pkg::xbc_cmd_type cur_reg, cur_next;
    logic [7:0] cnt_reg, cnt_next;
    logic capture;

    always_comb begin
        ctrl_next = ctrl_reg;
        width16_next = width16_reg;
        addr_next = addr_reg;
        table_latch_next = table_latch_reg;
        readdata_next = 32'h0000_0000;
        // Command writes stall while the queue is full
        wait_next = 1'b1;
        if (wait_reg && (avs_read || avs_write)) begin
            wait_next = avs_write && avs_address == `XBC_OFF_CMD && !fifo_in_ready;
        end
        if (wr_fire && avs_byteenable[0]) begin
            case (avs_address)
                `XBC_OFF_CTRL: begin
                    if (ctrl_visible) begin
                        ctrl_next.bus_disable_bit = avs_writedata[`XBC_CTRL_DIS_BIT];
                        ctrl_next.wait_field = avs_writedata[`XBC_CTRL_WAIT_LSB +: 2];
                        ctrl_next.write_mode_field = avs_writedata[`XBC_CTRL_WM_LSB +: 2];
                    end
                end
                `XBC_OFF_CONFIG: width16_next = avs_writedata[0];
                `XBC_OFF_ADDR: addr_next[7:0] = avs_writedata[7:0];
                `XBC_OFF_LATCH: table_latch_next[7:0] = avs_writedata[7:0];
                default: ;
            endcase
        end
        if (wr_fire && avs_byteenable[1]) begin
            if (avs_address == `XBC_OFF_ADDR) begin
                addr_next[15:8] = avs_writedata[15:8];
            end
            if (avs_address == `XBC_OFF_LATCH) begin
                table_latch_next[15:8] = avs_writedata[15:8];
            end
        end
        case (avs_address)
            `XBC_OFF_CTRL: readdata_next[7:0] = ctrl_visible ? ctrl_word(ctrl_reg) : '0;
            `XBC_OFF_CONFIG: readdata_next[0] = width16_reg;
            `XBC_OFF_ADDR: readdata_next[15:0] = addr_reg;
            `XBC_OFF_LATCH: readdata_next[15:0] = table_latch_reg;
            `XBC_OFF_STATUS: readdata_next[3:0] = {rvalid_reg, !fifo_out_valid, !fifo_in_ready,
                                                    state_reg != xbc_pkg::ST_IDLE};
            `XBC_OFF_RDATA: readdata_next[15:0] = rdata_reg;
            default: readdata_next = 32'h0000_0000;
        endcase
        rdata_next = capture ? ad_in : rdata_reg;
        // New read data wins over the clear by software
        rvalid_next = capture ? 1'b1 :
                      (rd_fire && avs_address == `XBC_OFF_RDATA) ? 1'b0 : rvalid_reg;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl_reg <= xbc_pkg::xbc_ctrl_type'(5'(`XBC_CTRL_RESET));
            width16_reg <= `XBC_CONFIG_RESET;
            addr_reg <= 16'h0000;
            table_latch_reg <= 16'h0000;
            rdata_reg <= 16'h0000;
            rvalid_reg <= 1'b0;
            wait_reg <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ctrl_reg <= ctrl_next;
            width16_reg <= width16_next;
            addr_reg <= addr_next;
            table_latch_reg <= table_latch_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            wait_reg <= wait_next;
            avs_readdata <= readdata_next;
        end
    end
    assign avs_waitrequest = wait_reg;

    xbc_fifo #(.WIDTH($bits(xbc_pkg::xbc_cmd_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .srst(srst),
        .in_data(fifo_in),
        .in_valid(push_cmd),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop)
    );

    // ======================================================================
    // Bus engine
    logic bus_allowed, is_read;
    logic [7:0] data_len;
    logic [15:0] ad_out_next, ad_oe_next, bus_oe;
    logic [15:0] wdata;
    logic ale_next, oe_n_next, wrh_n_next, wrl_n_next, ub_n_next, lb_n_next, owns_next;

    assign bus_allowed = ctrl_visible;
    assign fifo_pop = (state_reg == xbc_pkg::ST_IDLE) && fifo_out_valid && bus_allowed;
    assign is_read = !cur_reg.is_write;
    assign data_len = 8'(CLKS_PER_TCY * (8'd4 - {6'd0, ctrl_reg.wait_field})) - 8'd1;
    // Capture in the last clock of the data phase, when cnt_reg is zero, so the pins have settled
    assign capture = (state_reg == xbc_pkg::ST_DATA) && is_read && cnt_reg == 8'd0;

    always_comb begin
        state_next = state_reg;
        cur_next = cur_reg;
        cnt_next = (cnt_reg != 8'd0) ? cnt_reg - 8'd1 : 8'd0;
        case (state_reg)
            xbc_pkg::ST_IDLE: begin
                if (fifo_pop) begin
                    cur_next = fifo_out;
                    cnt_next = CLKS_PER_TCY - 8'd1;
                    state_next = xbc_pkg::ST_ADDR;
                end
            end
            xbc_pkg::ST_ADDR: begin
                if (cnt_reg == 8'd0) begin
                    cnt_next = data_len;
                    state_next = xbc_pkg::ST_DATA;
                end
            end
            xbc_pkg::ST_DATA: begin
                if (cnt_reg == 8'd0) begin
                    state_next = xbc_pkg::ST_IDLE;
                end
            end
            default: state_next = xbc_pkg::ST_IDLE;
        endcase
    end

    always_comb begin
        wdata = cur_reg.data;
        wrh_n_next = 1'b1;
        wrl_n_next = 1'b1;
        ub_n_next = 1'b1;
        lb_n_next = 1'b1;
        ale_next = (state_reg == xbc_pkg::ST_ADDR);
        oe_n_next = !((state_reg == xbc_pkg::ST_DATA) && is_read);
        bus_oe = 16'h0000;
        ad_out_next = 16'h0000;
        if (state_reg == xbc_pkg::ST_ADDR) begin
            bus_oe = 16'hffff;
            ad_out_next = cur_reg.addr;
        end else if (state_reg == xbc_pkg::ST_DATA && cur_reg.is_write) begin
            bus_oe = 16'hffff;
            if (!width16_reg) begin
                wdata = {8'h00, cur_reg.data[7:0]};
                wrl_n_next = 1'b0;
            end else if (ctrl_reg.write_mode_field[1]) begin
                wrh_n_next = 1'b0;
            end else begin
                wdata = {cur_reg.data[7:0], cur_reg.data[7:0]};
                if (ctrl_reg.write_mode_field[0]) begin
                    wrl_n_next = 1'b0;
                    ub_n_next = !cur_reg.addr[0];
                    lb_n_next = cur_reg.addr[0];
                end else begin
                    wrh_n_next = !cur_reg.addr[0];
                    wrl_n_next = cur_reg.addr[0];
                end
            end
            ad_out_next = wdata;
        end
        owns_next = bus_allowed && (!ctrl_reg.bus_disable_bit
                                    || state_reg != xbc_pkg::ST_IDLE);
        if (!owns_next) begin
            ad_out_next = port_out;
        end
        ad_oe_next = owns_next ? bus_oe : ~pin_direction_bit;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_reg <= xbc_pkg::ST_IDLE;
            cur_reg <= '0;
            cnt_reg <= 8'd0;
            ad_out <= 16'h0000;
            ad_oe <= 16'h0000;
            ale <= 1'b0;
            oe_n <= 1'b1;
            write_strobe_high_n <= 1'b1;
            write_strobe_low_n <= 1'b1;
            ub_n <= 1'b1;
            lb_n <= 1'b1;
            bus_owns_pins <= 1'b0;
        end else begin
            state_reg <= state_next;
            cur_reg <= cur_next;
            cnt_reg <= cnt_next;
            ad_out <= ad_out_next;
            ad_oe <= ad_oe_next;
            ale <= ale_next;
            oe_n <= oe_n_next;
            write_strobe_high_n <= wrh_n_next;
            write_strobe_low_n <= wrl_n_next;
            ub_n <= ub_n_next;
            lb_n <= lb_n_next;
            bus_owns_pins <= owns_next;
        end
    end

    // ======================================================================
    // Checks
    logic [7:0] phase_cnt;
    always_ff @(posedge clock) begin
        if (srst || state_reg != xbc_pkg::ST_DATA) begin
            phase_cnt <= 8'd0;
        end else begin
            phase_cnt <= phase_cnt + 8'd1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence data_phase_end_s;
        state_reg == xbc_pkg::ST_DATA && cnt_reg == 8'd0;
    endsequence

    ctrl_reset_a: assert property ($past(srst) |-> !ctrl_reg.bus_disable_bit)
        else $error("bus disable not clear after reset");
    ctrl_locked_a: assert property (!ctrl_visible |=> $stable(ctrl_reg))
        else $error("control changed while disabled");
    always_owned_a: assert property (bus_allowed && !ctrl_reg.bus_disable_bit
        |=> bus_owns_pins) else $error("bus released pins while enabled");
    ports_free_a: assert property (ctrl_reg.bus_disable_bit
        && state_reg == xbc_pkg::ST_IDLE |=> !bus_owns_pins && ad_oe == ~$past(pin_direction_bit))
        else $error("pins held by disabled bus");
    wait_length_a: assert property (data_phase_end_s
        |-> phase_cnt == 8'(CLKS_PER_TCY * (8'd4 - {6'd0, ctrl_reg.wait_field})) - 8'd1)
        else $error("data phase length wrong");
    word_write_a: assert property (state_reg == xbc_pkg::ST_DATA && cur_reg.is_write
        && width16_reg && ctrl_reg.write_mode_field[1] |=> !write_strobe_high_n
        && write_strobe_low_n && ad_out == $past(cur_reg.data))
        else $error("word write strobes wrong");
    narrow_write_a: assert property (!width16_reg |-> ##1 write_strobe_high_n [*2])
        else $error("high strobe in 8-bit mode");
    absent_ctrl_a: assert property (rd_fire && avs_address == `XBC_OFF_CTRL
        && !$past(ctrl_visible) |-> avs_readdata[7:0] == 8'h00)
        else $error("control readable when absent");
    addr_drive_a: assert property (state_reg == xbc_pkg::ST_ADDR
        |=> ad_oe == 16'hffff && ale && ad_out == $past(cur_reg.addr))
        else $error("address not driven");
    read_capture_a: assert property (capture |=> rvalid_reg
        && rdata_reg == $past(ad_in) ##1 state_reg inside {xbc_pkg::ST_IDLE, xbc_pkg::ST_ADDR})
        else $error("read data not captured");
    read_dir_a: assert property (state_reg == xbc_pkg::ST_DATA && is_read
        |=> ad_oe == 16'h0000 && !oe_n)
        else $error("pins driven during read");
endmodule : xbc_top
`default_nettype wire

// file: tb/xbc_mem_model.sv
// Purpose: External parallel memory on the multiplexed address/data pins
// Assumes: Address taken while ale is high, data driven while oe_n is low
// Notes: Released lines show the inverse of their last level
`timescale 1ns/10ps
`default_nettype none
module xbc_mem_model (
    input wire logic clock, // Core clock
    input wire logic [15:0] ad_out, // Pins driven by the block
    input wire logic ale, // Address latch enable
    input wire logic oe_n, // Read strobe
    input wire logic wrh_n, // High write strobe
    input wire logic wrl_n, // Low write strobe
    input wire logic ub_n, // Upper byte select
    input wire logic lb_n, // Lower byte select
    output logic [15:0] ad_in, // Pin levels seen by the block
    output logic [15:0] wr_val, // Last word written
    output logic [3:0] wr_seen // High, low, ub_n, lb_n during the write
);
    logic [15:0] mem [0:255];
    logic [15:0] addr = 16'h0000;
    logic [15:0] last = 16'h0000;
    // ==========================================================
    // Read side
    // A floating bus would settle arbitrarily, so show the inverse
    assign ad_in = oe_n ? ~last : mem[addr[7:0]];
    // ==========================================================
    // Address and write side
    always @(posedge clock) begin
        last <= ad_in;
        if (ale) begin
            addr <= ad_out;
        end
        if (!wrh_n || !wrl_n) begin
            mem[addr[7:0]] <= ad_out;
            wr_val <= ad_out;
            wr_seen <= {!wrh_n, !wrl_n, ub_n, lb_n};
        end
    end
endmodule : xbc_mem_model
`default_nettype wire

// file: tb/test_xbc_top.sv
// Purpose: Self-checking bench for the external bus control block
// Assumes: Instruction cycle shortened to two core clocks
// Notes: Registers reached over Avalon-MM, memory model on the pins
`timescale 1ns/10ps
`default_nettype none
module test_xbc_top;
    localparam logic [7:0] CPT = 8'h02;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic internal_only_mode = 1'b0;
    logic [15:0] port_out = 16'hc3a5;
    logic [15:0] pin_direction_bit = 16'h0f0f;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, ale, oe_n, wrh_n, wrl_n, ub_n, lb_n, bus_owns_pins;
    logic [15:0] ad_in, ad_out, ad_oe, wr_val;
    logic [3:0] wr_seen;
    logic owns_seen = 1'b0;
    int fails = 0;
    int check_count = 0;
    int low_cnt = 0;

    always #12.5 clock = ~clock;

    xbc_top #(.HAS_EXT_BUS(1'b1), .CLKS_PER_TCY(CPT), .FIFO_DEPTH(8)) xbc_top_i (
        .clock(clock), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .internal_only_mode(internal_only_mode), .port_out(port_out),
        .pin_direction_bit(pin_direction_bit), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
        .ale(ale), .oe_n(oe_n), .write_strobe_high_n(wrh_n), .write_strobe_low_n(wrl_n),
        .ub_n(ub_n), .lb_n(lb_n), .bus_owns_pins(bus_owns_pins));

    xbc_mem_model xbc_mem_model_i (.clock(clock), .ad_out(ad_out), .ale(ale), .oe_n(oe_n),
        .wrh_n(wrh_n), .wrl_n(wrl_n), .ub_n(ub_n), .lb_n(lb_n), .ad_in(ad_in),
        .wr_val(wr_val), .wr_seen(wr_seen));

    // Read strobe length of the latest access, restarted by each address phase
    always @(posedge clock) begin
        if (ale === 1'b1) low_cnt <= 0;
        else if (oe_n === 1'b0) low_cnt <= low_cnt + 1;
        if (bus_owns_pins === 1'b1) owns_seen <= 1'b1;
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0 && n < 1000) begin
            @(posedge clock);
            n++;
        end
        if (n >= 1000) fails++;
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // Lets an edge pass so the next request is not raised in the same step
        @(posedge clock);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus(1'b0, a, 32'h0, d);
    endtask : rd

    task automatic wait_idle();
        logic [31:0] r;
        int n;
        n = 0;
        repeat (2) @(posedge clock);
        rd(8'h14, r);
        while (n < 300 && (r[0] !== 1'b0 || r[2] !== 1'b1)) begin
            rd(8'h14, r);
            n++;
        end
        if (n >= 300) fails++;
    endtask : wait_idle

    task automatic tbl(input logic is_wr, input logic [15:0] a, input logic [15:0] d,
                       output logic [15:0] q);
        logic [31:0] r;
        wr(8'h08, {16'h0, a});
        wr(8'h0c, {16'h0, d});
        wr(8'h10, {31'h0, is_wr});
        wait_idle();
        rd(8'h18, r);
        q = r[15:0];
    endtask : tbl

    task automatic close_out();
        if (fails == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out

    // ==========================================================
    // Scenarios
    task automatic t_reset_and_ctrl();
        logic [31:0] r;
        logic [15:0] q;
        rd(8'h00, r);
        chk("ctrl reset", r, 32'h0);
        chk("owns after reset", {31'h0, bus_owns_pins}, 32'h1);
        wr(8'h00, 32'hff);
        rd(8'h00, r);
        chk("ctrl reserved bits", r, 32'hb3);
        internal_only_mode <= 1'b1;
        wr(8'h00, 32'h00);
        rd(8'h00, r);
        chk("ctrl disabled", r, 32'h0);
        internal_only_mode <= 1'b0;
        rd(8'h00, r);
        chk("ctrl kept", r, 32'hb3);
        @(negedge clock);
        chk("owns when off", {31'h0, bus_owns_pins}, 32'h0);
        chk("port data", {16'h0, ad_out}, {16'h0, port_out});
        chk("port dir", {16'h0, ad_oe}, {16'h0, ~pin_direction_bit});
        @(posedge clock);
        owns_seen <= 1'b0;
        tbl(1'b1, 16'h0020, 16'h1234, q);
        tbl(1'b0, 16'h0020, 16'h0, q);
        chk("owns in access", {31'h0, owns_seen}, 32'h1);
        chk("read word", {16'h0, q}, 32'h1234);
        rd(8'hfc, r);
        chk("unmapped", r, 32'h0);
    endtask : t_reset_and_ctrl

    task automatic t_wait();
        logic [15:0] q;
        for (int w = 0; w < 4; w++) begin
            wr(8'h00, {24'h0, 2'b00, 2'(w), 4'h2});
            tbl(1'b1, 16'h0040 + 16'(w), 16'h5a00 + 16'(w), q);
            tbl(1'b0, 16'h0040 + 16'(w), 16'h0, q);
            chk("wait read", {16'h0, q}, {16'h0, 16'h5a00 + 16'(w)});
            chk("wait length", low_cnt, 32'(CPT) * (4 - w));
        end
    endtask : t_wait

    task automatic wm(input logic cfg, input logic [1:0] m, input logic [15:0] a,
                      input logic [15:0] d, input logic [3:0] es, input logic [3:0] sm,
                      input logic [15:0] ev, input logic [15:0] vm);
        logic [15:0] q;
        wr(8'h04, {31'h0, cfg});
        wr(8'h00, {24'h0, 4'h3, 2'b00, m});
        tbl(1'b1, a, d, q);
        chk("strobes", {28'h0, wr_seen & sm}, {28'h0, es});
        chk("write word", {16'h0, wr_val & vm}, {16'h0, ev});
    endtask : wm

    task automatic t_fifo();
        logic [31:0] r;
        internal_only_mode <= 1'b1;
        wr(8'h08, 32'h0040);
        for (int i = 0; i < 8; i++) wr(8'h10, 32'h0);
        rd(8'h14, r);
        chk("fifo full", {30'h0, r[2:1]}, 32'h1);
        internal_only_mode <= 1'b0;
        wait_idle();
        rd(8'h18, r);
        chk("fifo drained read", r, 32'h5a00);
    endtask : t_fifo

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        t_reset_and_ctrl();
        t_wait();
        wm(1'b1, 2'b11, 16'h0010, 16'ha55a, 4'b1000, 4'hc, 16'ha55a, 16'hffff);
        wm(1'b1, 2'b01, 16'h0011, 16'h0037, 4'b0101, 4'hf, 16'h3737, 16'hffff);
        wm(1'b1, 2'b00, 16'h0013, 16'h0042, 4'b1000, 4'hc, 16'h4242, 16'hffff);
        wm(1'b1, 2'b00, 16'h0012, 16'h0042, 4'b0100, 4'hc, 16'h4242, 16'hffff);
        wm(1'b0, 2'b10, 16'h0014, 16'h0099, 4'b0100, 4'hc, 16'h0099, 16'h00ff);
        wr(8'h04, 32'h1);
        t_fifo();
        close_out();
    end

    initial begin
        repeat (40000) @(posedge clock);
        fails++;
        close_out();
    end
endmodule : test_xbc_top
`default_nettype wire
